//--- logic/float_multiplier.v
// Single-cycle floating-point multiplier producing extended results.
// Operands arrive from the register datapath on mclk_i; the result is
// registered at the edge that takes the request.
`timescale 1ns/1ps
`include "float_multiplier_map.vh"

module float_multiplier (
  input wire mclk_i,               // Processor clock, 200 MHz
  input wire rst_i,                // Synchronous reset, active high
  input wire start_i,              // Take operands this cycle
  input wire [1:0] fmt_a_i,        // Format of operand A
  input wire [1:0] fmt_b_i,        // Format of operand B
  input wire [39:0] opnd_a_i,      // Operand A
  input wire [39:0] opnd_b_i,      // Operand B
  output reg done_o,               // Result valid, one-cycle pulse
  output reg [39:0] result_o,      // Extended-precision product
  output reg zero_o,               // Result is zero
  output reg ovf_o,                // Exponent overflow, saturated
  output reg unf_o,                // Exponent underflow, forced zero
  output reg neg_o                 // Result is negative
);

  wire [7:0] exp_a;
  wire [7:0] exp_b;
  wire [24:0] mant_a;
  wire [24:0] mant_b;
  wire zero_a;
  wire zero_b;

  reg [49:0] prod;
  reg [9:0] exp_sum;
  reg [9:0] exp_fin;
  reg [1:0] shift;
  reg [32:0] mant_n;
  reg prod_zero;
  reg sum_ovf;
  reg fin_ovf;
  reg fin_unf;
  reg [39:0] next_result;
  reg next_zero;
  reg next_ovf;
  reg next_unf;

  // Signed compare of a 10-bit exponent against the top of the range.
  function above_max;
    input [9:0] e;
    begin
      above_max = ($signed(e) > $signed(`EXP_MAX));
    end
  endfunction

  float_operand_unpack unpack_a (
    .fmt_i(fmt_a_i),
    .word_i(opnd_a_i),
    .exp_o(exp_a),
    .mant_o(mant_a),
    .zero_o(zero_a)
  );

  float_operand_unpack unpack_b (
    .fmt_i(fmt_b_i),
    .word_i(opnd_b_i),
    .exp_o(exp_b),
    .mant_o(mant_b),
    .zero_o(zero_b)
  );

  always @* begin
    // Full product is kept so the shift choice sees every top bit.
    prod = $signed(mant_a) * $signed(mant_b);
    exp_sum = {{2{exp_a[7]}}, exp_a} + {{2{exp_b[7]}}, exp_b};
    // Product magnitude lies in [1,4], so at most two places are needed.
    if (prod[49] != prod[48]) begin
      shift = 2'h2;
      mant_n = prod[49:17];
    end else if (prod[48] != prod[47]) begin
      shift = 2'h1;
      mant_n = prod[48:16];
    end else begin
      shift = 2'h0;
      mant_n = prod[47:15];
    end
    exp_fin = exp_sum + {8'h00, shift};
    prod_zero = zero_a | zero_b | (prod == 50'h0);
    sum_ovf = above_max(exp_sum);
    fin_ovf = above_max(exp_fin);
    fin_unf = ($signed(exp_fin) < $signed(`EXP_MIN));
    next_zero = 1'b0;
    next_ovf = 1'b0;
    next_unf = 1'b0;
    if (prod_zero) begin
      next_result = `EXT_ZERO;
      next_zero = 1'b1;
    end else if (sum_ovf | fin_ovf) begin
      next_ovf = 1'b1;
      if (mant_n[32]) begin
        next_result = `EXT_MOST_NEG;
      end else begin
        next_result = `EXT_MOST_POS;
      end
    end else if (fin_unf) begin
      next_result = `EXT_ZERO;
      next_unf = 1'b1;
      next_zero = 1'b1;
    end else begin
      // Implied bit mant_n[31] is dropped; sign and fraction remain.
      next_result = {exp_fin[7:0], mant_n[32], mant_n[30:0]};
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      result_o <= `EXT_ZERO;
      zero_o <= 1'b1;
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
      neg_o <= 1'b0;
    end else begin
      done_o <= start_i;
      if (start_i) begin
        result_o <= next_result;
        zero_o <= next_zero;
        ovf_o <= next_ovf;
        unf_o <= next_unf;
        neg_o <= next_result[`EXT_SIGN];
      end
    end
  end

endmodule // float_multiplier

//--- logic/float_multiplier_map.vh
// Constants for the single-cycle floating-point multiplier datapath.
// Assumes operands come from the register datapath on the same clock.
// Overview of operation
// - Short operands widen, extended operands truncate, to single precision.
// - Every product leaves in the 40-bit extended-precision format.
// - Conversion, multiply, normalisation and special cases take one cycle.
// - Two 25-bit mantissas multiply into a kept 50-bit product.
// - Result exponent starts as the sum of both operand exponents.
// - Operands and results are normalised with an implied nonsign bit.
// - A zero product mantissa forces the exponent to -128.
// - A one-place right shift adds one to the exponent.
// - A two-place right shift adds two; no shift keeps the exponent.
// - Exponent overflow saturates to most positive or most negative value.
// - Exponent underflow gives mantissa zero and exponent -128.
// - Overflow is caught at the exponent sum and after normalisation.
// - A zero operand yields fraction 0, sign 0, exponent -128.
`ifndef FLOAT_MULTIPLIER_MAP_VH
`define FLOAT_MULTIPLIER_MAP_VH

// Operand format select codes.
`define FMT_SHORT 2'h0
`define FMT_SINGLE 2'h1
`define FMT_EXTENDED 2'h2

// Short format: exponent 15:12, sign 11, fraction 10:0.
`define SHT_EXP_HI 15
`define SHT_EXP_LO 12
`define SHT_SIGN 11
`define SHT_FRAC_HI 10
// Single format: exponent 31:24, sign 23, fraction 22:0.
`define SGL_EXP_HI 31
`define SGL_EXP_LO 24
`define SGL_SIGN 23
`define SGL_FRAC_HI 22
// Extended format: exponent 39:32, sign 31, fraction 30:0.
`define EXT_EXP_HI 39
`define EXT_EXP_LO 32
`define EXT_SIGN 31
`define EXT_FRAC_HI 30
`define EXT_TRUNC_LO 8

// Exponent value of the zero encoding and its short-format counterpart.
`define EXP_ZERO 8'h80
`define SHT_EXP_ZERO 4'h8
// Largest and smallest exponents that are not special.
`define EXP_MAX 10'h07F
`define EXP_MIN 10'h381

// Saturation and zero values in extended format.
`define EXT_MOST_POS 40'h7F7FFFFFFF
`define EXT_MOST_NEG 40'h7F80000000
`define EXT_ZERO 40'h8000000000

`endif

//--- logic/float_operand_unpack.v
// Operand converter: brings a short, single or extended operand to
// single precision and expands it into exponent and 25-bit mantissa.
// Purely combinational; the parent registers the result.
`timescale 1ns/1ps
`include "float_multiplier_map.vh"

module float_operand_unpack (
  input wire [1:0] fmt_i,          // Operand format select
  input wire [39:0] word_i,        // Operand, right aligned
  output reg [7:0] exp_o,          // Signed exponent
  output reg [24:0] mant_o,        // Signed mantissa, implied bit explicit
  output reg zero_o                // Operand is the zero encoding
);

  reg sign;
  reg [22:0] frac;

  always @* begin
    case (fmt_i)
      `FMT_SHORT: begin
        // Short zero exponent must map onto the wide zero exponent.
        if (word_i[`SHT_EXP_HI:`SHT_EXP_LO] == `SHT_EXP_ZERO) begin
          exp_o = `EXP_ZERO;
        end else begin
          exp_o = {{4{word_i[`SHT_EXP_HI]}},
                   word_i[`SHT_EXP_HI:`SHT_EXP_LO]};
        end
        sign = word_i[`SHT_SIGN];
        frac = {word_i[`SHT_FRAC_HI:0], 12'h000};
      end
      `FMT_EXTENDED: begin
        // Low fraction bits are dropped, not rounded.
        exp_o = word_i[`EXT_EXP_HI:`EXT_EXP_LO];
        sign = word_i[`EXT_SIGN];
        frac = word_i[`EXT_FRAC_HI:`EXT_TRUNC_LO];
      end
      default: begin
        exp_o = word_i[`SGL_EXP_HI:`SGL_EXP_LO];
        sign = word_i[`SGL_SIGN];
        frac = word_i[`SGL_FRAC_HI:0];
      end
    endcase
    mant_o = {sign, ~sign, frac};
    zero_o = (exp_o == `EXP_ZERO);
  end

endmodule // float_operand_unpack

//--- verif/float_multiplier_monitor.sv
// Checker for the multiplier handshake and result encodings.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ps
`include "float_multiplier_map.vh"
module float_multiplier_monitor (
  input wire mclk_i, // Clock
  input wire rst_i, // Reset
  input wire start_i, // Request
  input wire done_o, // Done pulse
  input wire [39:0] result_o, // Product
  input wire zero_o, // Zero flag
  input wire ovf_o, // Overflow flag
  input wire unf_o, // Underflow flag
  input wire neg_o // Sign flag
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_done_latency: assert property (start_i |=> done_o)
    else $error("done missing");
  chk_done_pulse: assert property (!start_i |=> !done_o)
    else $error("done without request");
  chk_result_hold: assert property (!start_i && !rst_i |=> $stable(result_o))
    else $error("result changed while idle");
  chk_zero_enc: assert property (zero_o |-> result_o == `EXT_ZERO)
    else $error("bad zero encoding");
  chk_unf_forced: assert property (unf_o |-> zero_o)
    else $error("underflow not zero");
  chk_ovf_sat: assert property (ovf_o |-> result_o == `EXT_MOST_POS ||
    result_o == `EXT_MOST_NEG) else $error("overflow not saturated");
  chk_sign_bit: assert property (neg_o == result_o[31])
    else $error("sign flag mismatch");
  chk_zero_prio: assert property (zero_o |-> !ovf_o)
    else $error("zero result saturated");
  cover property (done_o && ovf_o);
  cover property (done_o && unf_o);
  cover property (done_o && zero_o && !unf_o);
  cover property (done_o && start_i);
endmodule // float_multiplier_monitor
bind float_multiplier float_multiplier_monitor mon (.mclk_i, .rst_i,
  .start_i, .done_o, .result_o, .zero_o, .ovf_o, .unf_o, .neg_o);

//--- verif/float_multiplier_test.sv
// Self-checking bench for the multiplier with a write-back sink.
// Assumes the map header is on the include path.
`timescale 1ns/1ps
`include "float_multiplier_map.vh"
module float_multiplier_test;
  reg mclk_i = 0, rst_i = 1, start_i = 0;
  reg [1:0] fa = 0, fb = 0;
  reg [39:0] a = 0, b = 0;
  wire done_o, zero_o, ovf_o, unf_o, neg_o;
  wire [39:0] result_o, wb;
  integer failures = 0, compares = 0, cycles = 0, seed = 32'h9F8C, i;
  reg [31:0] rf;
  reg [63:0] ra, rb;
  always #2.5 mclk_i = ~mclk_i;
  float_multiplier uut (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i),
    .fmt_a_i(fa), .fmt_b_i(fb), .opnd_a_i(a), .opnd_b_i(b), .done_o(done_o),
    .result_o(result_o), .zero_o(zero_o), .ovf_o(ovf_o), .unf_o(unf_o),
    .neg_o(neg_o));
  result_sink sink (.mclk_i(mclk_i), .done_i(done_o), .data_i(result_o),
    .wb_o(wb));
  task check(input [39:0] got, exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Gives {exponent, 25-bit mantissa with the implied bit made explicit}.
  function [32:0] unpack(input [1:0] f, input [39:0] w);
    case (f)
      2'h0: unpack = {w[15:12] == 4'h8 ? 8'h80 : {{4{w[15]}}, w[15:12]},
        w[11], ~w[11], w[10:0], 12'h000};
      2'h2: unpack = {w[39:31], ~w[31], w[30:8]};
      default: unpack = {w[31:23], ~w[23], w[22:0]};
    endcase
  endfunction
  // Top four bits give the expected zero, overflow, underflow and sign flags.
  function [43:0] model(input [32:0] x, y);
    reg signed [49:0] p;
    reg signed [9:0] s, e;
    reg [1:0] sh;
    begin
      p = $signed(x[24:0]) * $signed(y[24:0]);
      sh = p[49] != p[48] ? 2'h2 : p[48] != p[47] ? 2'h1 : 2'h0;
      s = {{2{x[32]}}, x[32:25]} + {{2{y[32]}}, y[32:25]};
      e = s + sh;
      p = p >>> sh;
      if (x[32:25] == 8'h80 || y[32:25] == 8'h80 || p == 0)
        model = {4'h8, `EXT_ZERO};
      else if (s > 127 || e > 127)
        model = p[49] ? {4'h5, `EXT_MOST_NEG} : {4'h4, `EXT_MOST_POS};
      else if (e < -127)
        model = {4'hA, `EXT_ZERO};
      else
        model = {3'h0, p[47], e[7:0], p[47], p[45:15]};
    end
  endfunction
  task mul(input [1:0] f, g, input [39:0] x, y);
    reg [43:0] want;
    begin
      want = model(unpack(f, x), unpack(g, y));
      @(posedge mclk_i);
      start_i <= 1;
      fa <= f;
      fb <= g;
      a <= x;
      b <= y;
      @(posedge mclk_i);
      start_i <= 0;
      #1 check({39'h0, done_o}, 40'h1);
      check(result_o, want[39:0]);
      check({36'h0, zero_o, ovf_o, unf_o, neg_o},
        {36'h0, want[43:40]});
      @(posedge mclk_i);
      #1 check(wb, want[39:0]);
      check({39'h0, done_o}, 40'h0);
    end
  endtask
  // Two requests on consecutive edges; each result must stand one cycle.
  task burst(input [39:0] x, y);
    reg [43:0] w1, w2;
    begin
      w1 = model(unpack(2'h1, x), unpack(2'h1, x));
      w2 = model(unpack(2'h1, y), unpack(2'h1, y));
      @(posedge mclk_i);
      start_i <= 1;
      fa <= 2'h1;
      fb <= 2'h1;
      a <= x;
      b <= x;
      @(posedge mclk_i);
      a <= y;
      b <= y;
      #1 check(result_o, w1[39:0]);
      @(posedge mclk_i);
      start_i <= 0;
      #1 check(result_o, w2[39:0]);
      check({39'h0, done_o}, 40'h1);
      @(posedge mclk_i);
      #1 check(wb, w2[39:0]);
    end
  endtask
  task close_out;
    begin
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 0;
    #1 check(result_o, `EXT_ZERO);
    mul(2'h1, 2'h1, 40'h800000, 40'h800000);
    mul(2'h1, 2'h1, 40'h400000, 40'h400000);
    mul(2'h1, 2'h1, 40'h7F000000, 40'h7F000000);
    mul(2'h1, 2'h1, 40'h7F400000, 40'h800000);
    mul(2'h1, 2'h1, 40'h81000000, 40'h81000000);
    mul(2'h1, 2'h0, 40'h80000000, 40'h8000);
    burst(40'h400000, 40'h800000);
    // A reset in mid-run must clear a non-zero result.
    @(posedge mclk_i);
    rst_i <= 1;
    @(posedge mclk_i);
    rst_i <= 0;
    #1 check(result_o, `EXT_ZERO);
    check({39'h0, zero_o}, 40'h1);
    for (i = 0; i < 300; i = i + 1) begin
      rf = $random(seed);
      ra = {$random(seed), $random(seed)};
      rb = {$random(seed), $random(seed)};
      mul(rf[1:0], rf[3:2], ra[39:0], rb[39:0]);
    end
    close_out;
  end
endmodule // float_multiplier_test

//--- verif/result_sink.sv
// Write-back register of the processor datapath.
// Assumes done_i marks the one cycle in which data_i is new.
`timescale 1ns/1ps
module result_sink (
  input wire mclk_i, // Clock
  input wire done_i, // Result valid
  input wire [39:0] data_i, // Product
  output reg [39:0] wb_o // Written value
);
  // Only the done cycle is taken, so a late pulse writes stale data.
  always @(posedge mclk_i) begin
    if (done_i) wb_o <= data_i;
  end
endmodule // result_sink
